// File: hdl/plsp_blink.sv
`timescale 1ns/1ps
`include "plsp_cfg.svh"
// free-running divider giving a visible blink phase
module plsp_blink #(
  parameter int unsigned HALF_CYC = `PLSP_BLINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  output logic phase
);
  logic [31:0] count_q;
  logic phase_q;

  // count to half period, then flip phase
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_q <= 32'h0;
      phase_q <= 1'b0;
    end else if (count_q >= HALF_CYC - 1) begin
      count_q <= 32'h0;
      phase_q <= ~phase_q; // [R10]
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  assign phase = phase_q;
endmodule // plsp_blink

// File: hdl/plsp_cfg.svh
`ifndef PLSP_CFG_SVH
`define PLSP_CFG_SVH

// control register 0h and its strap-loaded bits
`define PLSP_CTRL_OFFSET 32'h0000_0000
`define PLSP_CTRL_ANEG_BIT 12
`define PLSP_CTRL_SPEED_BIT 13
// control register 1Eh, indicator-mode field
`define PLSP_IND_OFFSET 32'h0000_0078
`define PLSP_IND_MODE_LSB 14
`define PLSP_IND_MODE_MSB 15
`define PLSP_IND_MODE_RESET 2'h0
// status register for the block's own state
`define PLSP_STAT_OFFSET 32'h0000_0080
// blink half period
`define PLSP_BLINK_HALF_MS 100
`define PLSP_CLK_KHZ 25000
`define PLSP_BLINK_HALF_CYC (`PLSP_BLINK_HALF_MS * `PLSP_CLK_KHZ)

`endif

// File: hdl/plsp_ind_drv.sv
`timescale 1ns/1ps
// maps mode and status onto the two pin levels, registered
module plsp_ind_drv (
  input wire logic core_clk,
  input wire logic reset,
  plsp_ind_if.drv ind
);
  logic aD;
  logic bD;
  logic a_q;
  logic b_q;

  // pin level selection per mode, high means led off
  always_comb begin
    aD = 1'b1;
    bD = 1'b1;
    unique case (ind.mode)
      plsp_pkg::PLSP_MODE_LINK_ACT: begin
        if (!ind.linkUp) aD = 1'b1; // [R04]
        else if (ind.activity) aD = ind.blinkPhase; // [R04]
        else aD = 1'b0; // [R04]
        bD = ind.tenMegOperation; // [R06]
      end
      plsp_pkg::PLSP_MODE_LINK: begin
        aD = ~ind.linkUp; // [R05]
        bD = ind.activity ? ind.blinkPhase : 1'b1; // [R07]
      end
      default: begin
        aD = 1'b1; // [R08]
        bD = 1'b1; // [R08]
      end
    endcase
  end

  // registered pins; off while pins are still strap inputs
  always_ff @(posedge core_clk) begin
    if (reset || !ind.outEnable) begin
      a_q <= 1'b1;
      b_q <= 1'b1;
    end else begin
      a_q <= aD; // [R03]
      b_q <= bD; // [R06]
    end
  end

  assign ind.indicatorA = a_q;
  assign ind.indicatorB = b_q;
endmodule // plsp_ind_drv

// File: hdl/plsp_ind_if.sv
`timescale 1ns/1ps
// carries status and mode from the top to the indicator driver
interface plsp_ind_if;
  logic linkUp;
  logic activity;
  logic tenMegOperation;
  logic blinkPhase;
  logic outEnable;
  plsp_pkg::plsp_mode_e mode;
  logic indicatorA;
  logic indicatorB;
  modport ctrl (
    output linkUp, activity, tenMegOperation, blinkPhase, outEnable, mode,
    input indicatorA, indicatorB
  );
  modport drv (
    input linkUp, activity, tenMegOperation, blinkPhase, outEnable, mode,
    output indicatorA, indicatorB
  );
endinterface

// File: hdl/plsp_led_strap.sv
// How it works
// R01 - during reset, sample indicator_a pin into auto-negotiation enable bit 12 of 0h
// R02 - during reset, sample indicator_b pin into speed select bit 13 of 0h
// R03 - after reset indicator_a is an output chosen by field 1Eh[15:14]
// R04 - mode 00: indicator_a high without link, low with link, blinks on activity
// R05 - mode 01: indicator_a shows link only, high no link, low link
// R06 - indicator_b follows 1Eh[15:14]; mode 00 drives it high at 10 Mb/s
// R07 - mode 01: indicator_b high without activity, blinks with activity
// R08 - modes 10 and 11 reserved; pins held high (off)
// R09 - pins are pulled-up inputs during reset, outputs afterwards
// R10 - blink toggles at a fixed divided-clock rate from a parameter
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "plsp_cfg.svh"
module plsp_led_strap #(
  parameter int unsigned BLINK_HALF_CYC = `PLSP_BLINK_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic linkUp,
  input wire logic activity,
  input wire logic tenMegOperation,
  input wire logic indicatorAIn,
  output logic indicatorAOut,
  output logic indicatorAOe,
  output logic indicatorAPullup,
  input wire logic indicatorBIn,
  output logic indicatorBOut,
  output logic indicatorBOe,
  output logic indicatorBPullup,
  output logic autonegEnableStrap,
  output logic speedSelect
);
  plsp_ind_if ind ();
  plsp_pkg::plsp_state_e state_q;
  logic aneg_q;
  logic speed_q;
  logic [1:0] mode_q;
  logic [31:0] rdata_q;
  logic apbWrite;
  logic apbRead;
  logic hitCtrl;
  logic hitInd;
  logic hitStat;
  logic blinkPhase;

  // strap phase while reset is high, one latch cycle, then run
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= plsp_pkg::PLSP_ST_STRAP;
    end else begin
      unique case (state_q)
        plsp_pkg::PLSP_ST_STRAP: state_q <= plsp_pkg::PLSP_ST_LATCH;
        plsp_pkg::PLSP_ST_LATCH: state_q <= plsp_pkg::PLSP_ST_RUN;
        plsp_pkg::PLSP_ST_RUN: state_q <= plsp_pkg::PLSP_ST_RUN;
      endcase
    end
  end

  // apb decode, zero wait state
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !pwrite;
  assign hitCtrl = (paddr == `PLSP_CTRL_OFFSET);
  assign hitInd = (paddr == `PLSP_IND_OFFSET);
  assign hitStat = (paddr == `PLSP_STAT_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitCtrl || hitInd || hitStat);

  // strap capture while pins are inputs; software may rewrite later
  always_ff @(posedge core_clk) begin
    if (state_q == plsp_pkg::PLSP_ST_STRAP) begin
      aneg_q <= indicatorAIn; // [R01]
      speed_q <= indicatorBIn; // [R02]
    end else if (apbWrite && hitCtrl) begin
      aneg_q <= pwdata[`PLSP_CTRL_ANEG_BIT];
      speed_q <= pwdata[`PLSP_CTRL_SPEED_BIT];
    end
  end

  // indicator-mode field
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= `PLSP_IND_MODE_RESET;
    end else if (apbWrite && hitInd) begin
      mode_q <= pwdata[`PLSP_IND_MODE_MSB:`PLSP_IND_MODE_LSB]; // [R03]
    end
  end

  // read data captured in setup cycle, held for the access cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdata_q <= 32'h0;
    end else if (apbRead && !penable) begin
      rdata_q <= 32'h0;
      if (hitCtrl) begin
        rdata_q[`PLSP_CTRL_ANEG_BIT] <= aneg_q;
        rdata_q[`PLSP_CTRL_SPEED_BIT] <= speed_q;
      end else if (hitInd) begin
        rdata_q[`PLSP_IND_MODE_MSB:`PLSP_IND_MODE_LSB] <= mode_q;
      end else if (hitStat) begin
        rdata_q <= {26'h0, indicatorBOut, indicatorAOut, indicatorAOe,
                    tenMegOperation, activity, linkUp};
      end
    end
  end

  assign prdata = rdata_q;

  // hand status and mode to the pin driver
  assign ind.linkUp = linkUp;
  assign ind.activity = activity;
  assign ind.tenMegOperation = tenMegOperation;
  assign ind.blinkPhase = blinkPhase;
  assign ind.mode = plsp_pkg::plsp_mode_e'(mode_q);
  assign ind.outEnable = (state_q == plsp_pkg::PLSP_ST_RUN); // [R09]

  plsp_blink #(
    .HALF_CYC(BLINK_HALF_CYC)
  ) u_blink (
    .core_clk(core_clk),
    .reset(reset),
    .phase(blinkPhase)
  );

  plsp_ind_drv u_drv (
    .core_clk(core_clk),
    .reset(reset),
    .ind(ind.drv)
  );

  // pins are pulled-up inputs until run, then driven outputs
  assign indicatorAOe = (state_q == plsp_pkg::PLSP_ST_RUN); // [R09]
  assign indicatorBOe = (state_q == plsp_pkg::PLSP_ST_RUN); // [R09]
  assign indicatorAPullup = !indicatorAOe; // [R09]
  assign indicatorBPullup = !indicatorBOe; // [R09]
  assign indicatorAOut = ind.indicatorA;
  assign indicatorBOut = ind.indicatorB;
  assign autonegEnableStrap = aneg_q;
  assign speedSelect = speed_q;
endmodule // plsp_led_strap

// File: hdl/plsp_pkg.sv
package plsp_pkg;
  // indicator-mode codes of the two-bit field
  typedef enum logic [1:0] {
    PLSP_MODE_LINK_ACT = 2'h0,
    PLSP_MODE_LINK = 2'h1,
    PLSP_MODE_RSV2 = 2'h2,
    PLSP_MODE_RSV3 = 2'h3
  } plsp_mode_e;
  // reset sequencing states
  typedef enum logic [2:0] {
    PLSP_ST_STRAP = 3'h1,
    PLSP_ST_LATCH = 3'h2,
    PLSP_ST_RUN = 3'h4
  } plsp_state_e;
endpackage

// File: testbench/plsp_led_strap_asserts.sv
`timescale 1ns/1ps
module plsp_led_strap_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic linkUp,
  input wire logic activity,
  input wire logic tenMegOperation,
  input wire logic indicatorAIn,
  input wire logic indicatorAOut,
  input wire logic indicatorAOe,
  input wire logic indicatorAPullup,
  input wire logic indicatorBIn,
  input wire logic indicatorBOut,
  input wire logic indicatorBOe,
  input wire logic autonegEnableStrap,
  input wire logic speedSelect
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // two edges past release, straps are settled
  sequence sReleased;
    $fell(reset) ##2 1'b1;
  endsequence
  AST_STRAP_A: assert property (sReleased |->
    autonegEnableStrap == $past(indicatorAIn, 2)) else $error("strap a");
  AST_STRAP_B: assert property (sReleased |->
    speedSelect == $past(indicatorBIn, 2)) else $error("strap b");
  AST_OE_UP: assert property ($fell(reset) |->
    !indicatorAOe ##1 !indicatorAOe ##1 indicatorAOe) else $error("oe late");
  AST_OE_RST: assert property (disable iff (1'b0) reset |=>
    !indicatorAOe && !indicatorBOe && indicatorAOut && indicatorBOut)
    else $error("pins not released in reset");
  AST_PULL: assert property (indicatorAPullup == !indicatorAOe)
    else $error("pull-up wrong");
  AST_LINK_A: assert property (indicatorAOe && $past(indicatorAOe) &&
    !$past(linkUp) |-> indicatorAOut) else $error("a lit without link");
  AST_OFF_B: assert property (indicatorBOe && $past(indicatorBOe) &&
    $past(tenMegOperation) && !$past(activity) |-> indicatorBOut)
    else $error("b lit at ten meg");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("slverr outside access");
endmodule // plsp_led_strap_asserts
bind plsp_led_strap plsp_led_strap_asserts chk_u (.core_clk, .reset, .psel,
  .penable, .pslverr, .linkUp, .activity, .tenMegOperation, .indicatorAIn,
  .indicatorAOut, .indicatorAOe, .indicatorAPullup, .indicatorBIn,
  .indicatorBOut, .indicatorBOe, .autonegEnableStrap, .speedSelect);

// File: testbench/plsp_led_strap_test.sv
`timescale 1ns/1ps
module plsp_led_strap_test;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, linkUp = 1'b0, activity = 1'b0;
  logic tenMegOperation = 1'b0, strapA = 1'b1, strapB = 1'b0, err, v;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, indicatorAIn, indicatorAOut, indicatorAOe;
  logic indicatorAPullup, indicatorBIn, indicatorBOut, indicatorBOe;
  logic indicatorBPullup, autonegEnableStrap, speedSelect;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  plsp_led_strap #(.BLINK_HALF_CYC(4)) dut_u (.core_clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .linkUp,
    .activity, .tenMegOperation, .indicatorAIn, .indicatorAOut,
    .indicatorAOe, .indicatorAPullup, .indicatorBIn, .indicatorBOut,
    .indicatorBOe, .indicatorBPullup, .autonegEnableStrap, .speedSelect);
  plsp_pin_model pinA_u (.oe(indicatorAOe), .drive(indicatorAOut),
    .strapHigh(strapA), .level(indicatorAIn));
  plsp_pin_model pinB_u (.oe(indicatorBOe), .drive(indicatorBOut),
    .strapHigh(strapB), .level(indicatorBIn));
  // compare and count
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, result left in rd and err
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // reset with given board straps, then check latched bits
  task automatic strapCase(logic a, logic b);
    strapA <= a;
    strapB <= b;
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("pull a rst", indicatorAPullup, 1'b1);
    chk("pull b rst", indicatorBPullup, 1'b1);
    chk("oe b rst", indicatorBOe, 1'b0);
    reset <= 1'b0;
    apb(1'b0, 32'h0, 32'h0);
    chk("oe a run", indicatorAOe, 1'b1);
    chk("oe b run", indicatorBOe, 1'b1);
    chk("pull b run", indicatorBPullup, 1'b0);
    chk("ready", pready, 1'b1);
    chk("aneg", autonegEnableStrap, a);
    chk("speed", speedSelect, b);
    chk("ctrl", rd[13:12], {b, a});
  endtask
  // program mode, apply status, let pins settle
  task automatic setMode(logic [1:0] m, logic l, logic act, logic ten);
    linkUp <= l;
    activity <= act;
    tenMegOperation <= ten;
    apb(1'b1, 32'h78, {16'h0, m, 14'h0});
    apb(1'b0, 32'h78, 32'h0);
    chk("mode", rd[15:14], m);
    repeat (2) @(posedge core_clk);
  endtask
  // a blinking pin inverts every half period
  task automatic blinkChk(logic useB);
    v = useB ? indicatorBOut : indicatorAOut;
    repeat (4) @(posedge core_clk);
    chk("blink", useB ? indicatorBOut : indicatorAOut, !v);
  endtask
  // verdict and end of run
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    strapCase(1'b1, 1'b0);
    strapCase(1'b0, 1'b1);
    setMode(2'h0, 1'b0, 1'b0, 1'b1);
    chk("a nolink", indicatorAOut, 1'b1);
    chk("b ten", indicatorBOut, 1'b1);
    setMode(2'h0, 1'b1, 1'b0, 1'b0);
    chk("a link", indicatorAOut, 1'b0);
    chk("b hundred", indicatorBOut, 1'b0);
    setMode(2'h0, 1'b1, 1'b1, 1'b0);
    blinkChk(1'b0);
    setMode(2'h1, 1'b1, 1'b1, 1'b1);
    chk("a linkonly", indicatorAOut, 1'b0);
    blinkChk(1'b1);
    setMode(2'h1, 1'b0, 1'b0, 1'b0);
    chk("a off", indicatorAOut, 1'b1);
    chk("b idle", indicatorBOut, 1'b1);
    apb(1'b0, 32'h80, 32'h0);
    chk("status", rd, 32'h0000_0038);
    chk("status err", err, 1'b0);
    for (int m = 2; m < 4; m++) begin
      setMode(m[1:0], 1'b1, 1'b1, 1'b0);
      chk("rsv", {indicatorAOut, indicatorBOut}, 2'h3);
    end
    apb(1'b0, 32'h40, 32'h0);
    chk("slverr", err, 1'b1);
    apb(1'b1, 32'h0, 32'h0000_2000);
    chk("speed wr", speedSelect, 1'b1);
    chk("aneg wr", autonegEnableStrap, 1'b0);
    summarize();
  end
endmodule // plsp_led_strap_test

// File: testbench/plsp_pin_model.sv
`timescale 1ns/1ps
// led plus board strap resistor on one indicator pin
module plsp_pin_model (
  input wire logic oe,
  input wire logic drive,
  input wire logic strapHigh,
  output logic level
);
  // board resistor sets an undriven pin, outweighing the weak pull-up
  assign level = oe ? drive : strapHigh;
endmodule // plsp_pin_model
